// ===== logic/tpc_pkg.sv
// Purpose: constants and types for the target pin control block
// Assumes: link clock drives the shift engine, system clock faces the host
// Notes:   pin indices, direction masks and timing counts live here
// Operation
// RQ1 - pin directions follow selected operating mode
// RQ2 - low reference voltage floats every output; the pseudo ground pull-low is not released
// RQ3 - drivers enabled only during an operation
// RQ4 - drive outputs high before floating them
// RQ5 - halt low for logic-part jtag work
// RQ6 - halt high for other jtag targets
// RQ7 - halt floats when disabled, spi, serial
// RQ8 - halt uses a three-state driver
// RQ9 - data and select change on clock fall
// RQ10 - shift clock up to 24 MHz, selectable
// RQ11 - pseudo ground open drain, never high
// RQ12 - pseudo ground low during any operation
// RQ13 - jtag: data, clock, select out; data-in in
package tpc_pkg;
    ////////////////////////////////////////////////////////////////////////
    // operating modes and link states
    typedef enum logic [1:0] {TPC_JTAG, TPC_SPI, TPC_SERIAL} tpc_mode_t;
    typedef enum logic [1:0] {TPC_IDLE, TPC_SHIFT, TPC_PARK} tpc_link_t;
    ////////////////////////////////////////////////////////////////////////
    // target pin positions within the five-pin vectors
    localparam int PIN_DOUT = 0;   // serial data to target
    localparam int PIN_DIN  = 1;   // serial data from target
    localparam int PIN_SCLK = 2;   // target_shift_clock
    localparam int PIN_MSEL = 3;   // target_mode_select_line
    localparam int PIN_HALT = 4;   // hold/halt line
    localparam int NPIN     = 5;
    // output masks per mode; halt is handled on its own
    localparam logic [4:0] DIR_JTAG   = 5'h0d;
    localparam logic [4:0] DIR_SPI    = 5'h0d;
    localparam logic [4:0] DIR_SERIAL = 5'h0d;
    ////////////////////////////////////////////////////////////////////////
    // widths and reset values
    localparam int          WORD       = 32;
    localparam logic [4:0]  PIN_RST    = 5'h1f;
    localparam int          VREF_MIN_MV = 1300;  // comparator trip point
    ////////////////////////////////////////////////////////////////////////
    // shift clock timing
    localparam longint SCLK_MAX_HZ = 24000000;
    localparam longint SCLK_LOW_PS = 20800;      // low phase at top rate
    localparam longint LINK_HZ     = 8000000;
    localparam longint HALF_RAW =
        (SCLK_LOW_PS * LINK_HZ + 64'd999999999999) / 64'd1000000000000;
    localparam logic [3:0] HALF_MIN = (HALF_RAW < 1) ? 4'h0 : 4'(HALF_RAW - 1);
endpackage

// ===== logic/tpc_target_port.sv
// Purpose: drives the five shared target pins, pseudo ground and halt
// Assumes: link_clk_i runs freely; host holds inputs steady while busy
// Notes:   system side takes commands, link side shifts the bits
`timescale 1ns/1ps
module tpc_target_port
    import tpc_pkg::*;
(
    input  wire logic              clk_i,        // system clock, 40 MHz
    input  wire logic              rst_i,        // async reset, high
    input  wire logic              link_clk_i,   // shift engine clock
    input  wire tpc_mode_t         mode_i,       // operating mode
    input  wire logic              halt_en_i,    // hold/halt function on
    input  wire logic              halt_lpart_i, // target is logic part
    input  wire logic [3:0]        div_i,        // half period minus one
    input  wire logic [4:0]        len_i,        // bit count minus one
    input  wire logic [WORD-1:0]   tx_data_i,    // data bits, lsb first
    input  wire logic [WORD-1:0]   tx_sel_i,     // select bits, lsb first
    input  wire logic              start_i,      // start pulse
    input  wire logic              vref_low_i,   // reference below trip
    input  wire logic [NPIN-1:0]   tgt_pin_i,    // pin levels seen
    output logic [NPIN-1:0]        tgt_pin_o,    // pin drive values
    output logic [NPIN-1:0]        tgt_pin_oe_o, // pin drive enables
    output logic                   pseudo_ground_line_o,       // pseudo ground value
    output logic                   pseudo_ground_line_oe_o,    // pseudo ground pull low
    output logic                   busy_o,       // operation running
    output logic                   done_o,       // operation finished
    output logic [WORD-1:0]        rx_data_o     // captured data bits
);
    ////////////////////////////////////////////////////////////////////////
    // system domain state
    logic            req_tog, next_req_tog;   // request toggle
    logic            busy, next_busy;
    logic            done, next_done;
    logic [WORD-1:0] rx_out, next_rx_out;
    logic [WORD-1:0] h_data, next_h_data;     // held command words
    logic [WORD-1:0] h_sel, next_h_sel;
    logic [4:0]      h_len, next_h_len;
    logic [3:0]      h_div, next_h_div;
    tpc_mode_t       h_mode, next_h_mode;
    logic            h_hen, next_h_hen;
    logic            h_hlp, next_h_hlp;
    logic            ack_s1, ack_s2, ack_s3;  // ack toggle synchroniser
    ////////////////////////////////////////////////////////////////////////
    // link domain state
    tpc_link_t       st, next_st;
    logic [3:0]      hcnt, next_hcnt;         // half period counter
    logic [4:0]      bitn, next_bitn;         // current bit
    logic [WORD-1:0] rx, next_rx;
    logic [NPIN-1:0] pin, next_pin;
    logic [NPIN-1:0] oe, next_oe;
    logic            pg_oe, next_pg_oe;
    logic            ack_tog, next_ack_tog;
    logic [3:0]      div, next_div;
    logic            cap, next_cap;           // din capture due at this edge
    logic [4:0]      cap_bit, next_cap_bit;   // bit that the capture fills
    logic            req_s1, req_s2, req_s3;  // request synchroniser
    logic            vr_s1, vr_s2;            // reference low sync
    logic [NPIN-1:0] in_s1, in_s2;            // pin input sync
    logic [NPIN-1:0] dir;                     // mode output mask
    logic            halt_on;                 // halt driven this run
    logic            pg_zero;                 // pseudo ground value
    ////////////////////////////////////////////////////////////////////////
    // system next state: capture command, finish on ack edge
    always_comb begin
        next_req_tog = req_tog;
        next_busy    = busy;
        next_done    = 1'b0;
        next_rx_out  = rx_out;
        next_h_data  = h_data;
        next_h_sel   = h_sel;
        next_h_len   = h_len;
        next_h_div   = h_div;
        next_h_mode  = h_mode;
        next_h_hen   = h_hen;
        next_h_hlp   = h_hlp;
        if (!busy && start_i) begin
            // held words stay frozen until the ack returns
            next_h_data  = tx_data_i;
            next_h_sel   = tx_sel_i;
            next_h_len   = len_i;
            next_h_div   = (div_i < HALF_MIN) ? HALF_MIN : div_i; // [RQ10]
            next_h_mode  = mode_i;
            next_h_hen   = halt_en_i;
            next_h_hlp   = halt_lpart_i;
            next_req_tog = ~req_tog;
            next_busy    = 1'b1;
        end else if (busy && (ack_s2 != ack_s3)) begin
            // link result is stable once its ack is seen
            next_rx_out = rx;
            next_busy   = 1'b0;
            next_done   = 1'b1;
        end
    end

    // system registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_tog <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
            rx_out  <= '0;
            h_data  <= '0;
            h_sel   <= '0;
            h_len   <= 5'h00;
            h_div   <= 4'h0;
            h_mode  <= TPC_JTAG;
            h_hen   <= 1'b0;
            h_hlp   <= 1'b0;
            ack_s1  <= 1'b0;
            ack_s2  <= 1'b0;
            ack_s3  <= 1'b0;
        end else begin
            req_tog <= next_req_tog;
            busy    <= next_busy;
            done    <= next_done;
            rx_out  <= next_rx_out;
            h_data  <= next_h_data;
            h_sel   <= next_h_sel;
            h_len   <= next_h_len;
            h_div   <= next_h_div;
            h_mode  <= next_h_mode;
            h_hen   <= next_h_hen;
            h_hlp   <= next_h_hlp;
            ack_s1  <= ack_tog;
            ack_s2  <= ack_s1;
            ack_s3  <= ack_s2;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // link side synchronisers; first stages feed only second stages
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            vr_s1  <= 1'b1;
            vr_s2  <= 1'b1;
            in_s1  <= '0;
            in_s2  <= '0;
        end else begin
            req_s1 <= req_tog;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            vr_s1  <= vref_low_i;
            vr_s2  <= vr_s1;
            in_s1  <= tgt_pin_i;
            in_s2  <= in_s1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // pin direction per mode
    always_comb begin
        case (h_mode)
            TPC_JTAG:   dir = DIR_JTAG;     // [RQ1] [RQ13]
            TPC_SPI:    dir = DIR_SPI;      // [RQ1]
            TPC_SERIAL: dir = DIR_SERIAL;   // [RQ1]
            default:    dir = '0;
        endcase
        // halt only in jtag with the function on
        halt_on = (h_mode == TPC_JTAG) && h_hen;                // [RQ7]
    end
    ////////////////////////////////////////////////////////////////////////
    // link next state: shift, park high, release
    always_comb begin
        next_st      = st;
        next_hcnt    = hcnt;
        next_bitn    = bitn;
        next_rx      = rx;
        next_pin     = pin;
        next_oe      = oe;
        next_pg_oe   = pg_oe;
        next_ack_tog = ack_tog;
        next_div     = div;
        next_cap     = 1'b0;
        next_cap_bit = cap_bit;
        case (st)
            TPC_IDLE: begin
                next_oe    = '0;                                // [RQ3]
                next_pg_oe = 1'b0;                              // [RQ12]
                if (req_s2 != req_s3) begin
                    next_st    = TPC_SHIFT;
                    next_div   = h_div;                         // [RQ10]
                    next_hcnt  = 4'h0;
                    next_bitn  = 5'h00;
                    next_rx    = '0;
                    next_pin[PIN_DOUT] = h_data[0];
                    next_pin[PIN_MSEL] = h_sel[0];
                    next_pin[PIN_SCLK] = 1'b0;
                    next_pin[PIN_HALT] = ~h_hlp;                // [RQ5] [RQ6]
                    next_oe    = dir;                           // [RQ1]
                    next_oe[PIN_HALT] = halt_on;                // [RQ8]
                    next_pg_oe = 1'b1;                          // [RQ12]
                end
            end
            TPC_SHIFT: begin
                if (hcnt == div) begin
                    next_hcnt = 4'h0;
                    if (!pin[PIN_SCLK]) begin
                        next_pin[PIN_SCLK] = 1'b1;              // target samples here
                    end else begin
                        // din is taken one edge after this fall, see below
                        next_cap     = 1'b1;
                        next_cap_bit = bitn;
                        next_pin[PIN_SCLK] = 1'b0;
                        if (bitn == h_len) begin
                            next_st = TPC_PARK;
                            next_pin[PIN_DOUT] = 1'b1;          // [RQ4]
                            next_pin[PIN_MSEL] = 1'b1;          // [RQ4]
                            next_pin[PIN_HALT] = 1'b1;          // [RQ4]
                        end else begin
                            next_bitn = bitn + 5'h01;
                            next_pin[PIN_DOUT] = h_data[bitn + 5'h01]; // [RQ9]
                            next_pin[PIN_MSEL] = h_sel[bitn + 5'h01];  // [RQ9]
                        end
                    end
                end else begin
                    next_hcnt = hcnt + 4'h1;
                end
            end
            TPC_PARK: begin
                // half period at 1 with the clock low, one with it driven high, then float
                if (hcnt == div) begin
                    next_hcnt = 4'h0;
                    if (!pin[PIN_SCLK]) begin
                        next_pin[PIN_SCLK] = 1'b1;              // [RQ4]
                    end else begin
                        next_st      = TPC_IDLE;
                        next_oe      = '0;                      // [RQ3] [RQ4]
                        next_pg_oe   = 1'b0;                    // [RQ12]
                        next_ack_tog = ~ack_tog;
                    end
                end else begin
                    next_hcnt = hcnt + 4'h1;
                end
            end
            default: begin
                next_st = TPC_IDLE;
                next_oe = '0;
            end
        endcase
        // late capture: the synchroniser now holds the level seen one link cycle before the fall
        if (cap) begin
            next_rx[cap_bit] = in_s2[PIN_DIN];
        end
        // low reference voltage overrides every target pin driver, but not the pseudo ground pull-low
        if (vr_s2) begin
            next_oe = '0;                                       // [RQ2]
        end
    end

    // link registers; pseudo_ground_line value is a flop that only ever holds zero
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st      <= TPC_IDLE;
            hcnt    <= 4'h0;
            bitn    <= 5'h00;
            rx      <= '0;
            pin     <= PIN_RST;
            oe      <= '0;
            pg_oe   <= 1'b0;
            ack_tog <= 1'b0;
            div     <= 4'h0;
            cap     <= 1'b0;
            cap_bit <= 5'h00;
            pg_zero <= 1'b0;
        end else begin
            st      <= next_st;
            hcnt    <= next_hcnt;
            bitn    <= next_bitn;
            rx      <= next_rx;
            pin     <= next_pin;
            oe      <= next_oe;
            pg_oe   <= next_pg_oe;
            ack_tog <= next_ack_tog;
            div     <= next_div;
            cap     <= next_cap;
            cap_bit <= next_cap_bit;
            pg_zero <= 1'b0;                                    // [RQ11]
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flop
    assign tgt_pin_o    = pin;
    assign tgt_pin_oe_o = oe;
    assign pseudo_ground_line_o       = pg_zero;                              // [RQ11]
    assign pseudo_ground_line_oe_o    = pg_oe;
    assign busy_o       = busy;
    assign done_o       = done;
    assign rx_data_o    = rx_out;
endmodule

// ===== testbench/tb_tpc_target_port.sv
// Purpose: self-checking bench for the target pin control block
// Assumes: inputs change 2 ns after the system clock edge
// Notes:   undriven pins other than din settle high through their pull-ups
`timescale 1ns/1ps
module tb_tpc_target_port
    import tpc_pkg::*;
();
    logic            clk_i = 0, link_clk_i = 0, rst_i = 1, start_i = 0, vref_low_i = 0;
    tpc_mode_t       mode_i;
    logic            halt_en_i, halt_lpart_i, pseudo_ground_line_o, pseudo_ground_line_oe_o, busy_o, done_o, din, mdl_clr;
    logic [3:0]      div_i;
    logic [4:0]      len_i;
    logic [WORD-1:0] tx_data_i, tx_sel_i, rx_data_o, pat, cap_d, cap_s;
    logic [NPIN-1:0] tgt_pin_i, tgt_pin_o, tgt_pin_oe_o;
    logic            any_oe, halt_oe, halt_val;  // pin activity seen by the monitor
    int              miscompares = 0, check_count = 0;
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        #7;
        forever #62.5 link_clk_i = ~link_clk_i;
    end
    // wire levels: driven value, else pull-up, din from the target
    assign tgt_pin_i = (tgt_pin_oe_o & tgt_pin_o) | (~tgt_pin_oe_o & {3'h7, din, 1'h1});
    tpc_target_port uut (.clk_i, .rst_i, .link_clk_i, .mode_i, .halt_en_i, .halt_lpart_i, .div_i,
        .len_i, .tx_data_i, .tx_sel_i, .start_i, .vref_low_i, .tgt_pin_i, .tgt_pin_o, .tgt_pin_oe_o,
        .pseudo_ground_line_o, .pseudo_ground_line_oe_o, .busy_o, .done_o, .rx_data_o);
    tpc_target_model mdl (.clr_i(mdl_clr), .sclk_i(tgt_pin_i[PIN_SCLK]), .sdi_i(tgt_pin_i[PIN_DOUT]),
        .sel_i(tgt_pin_i[PIN_MSEL]), .pat_i(pat), .sdo_o(din), .cap_d_o(cap_d), .cap_s_o(cap_s));
    // record driven pins and the first driven halt level of each run
    always @(posedge link_clk_i) begin
        if (tgt_pin_oe_o != 5'h00) any_oe <= 1'b1;
        if (tgt_pin_oe_o[PIN_HALT]) halt_oe <= 1'b1;
        if (tgt_pin_oe_o[PIN_HALT] && !halt_oe) halt_val <= tgt_pin_o[PIN_HALT];
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task automatic chk(input logic [WORD-1:0] got, input logic [WORD-1:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one operation, with a refused second start while busy
    task automatic run(input tpc_mode_t m, input logic en, lp, input logic [3:0] d, input logic [4:0] l,
                       input logic [WORD-1:0] dt, sl, pt);
        logic [WORD-1:0] mask;
        int i;
        mask = WORD'((64'h1 << (l + 1)) - 64'h1);
        mode_i = m;
        {halt_en_i, halt_lpart_i, div_i, len_i} = {en, lp, d, l};
        {tx_data_i, tx_sel_i, pat} = {dt, sl, pt};
        {mdl_clr, any_oe, halt_oe} = 3'h4;
        step(1);
        mdl_clr = 0;
        start_i = 1;
        step(1);
        start_i = 0;
        step(4);
        start_i = 1;
        step(1);
        start_i = 0;
        for (i = 0; i < 3000 && done_o !== 1'b1; i++) step(1);
        if (i == 3000) begin
            miscompares++;
            $display("unexpected at %0t: no completion", $time);
            end_of_test;
        end
        if (!vref_low_i) begin
            chk(rx_data_o, pt & mask);
            chk(cap_d & mask, dt & mask);
            chk(cap_s & mask, sl & mask);
        end
        chk(halt_oe, en && m == TPC_JTAG && !vref_low_i);
        step(12);
        chk(busy_o, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mode_i = TPC_JTAG;
        {halt_en_i, halt_lpart_i, div_i, len_i} = '0;
        {tx_data_i, tx_sel_i, pat, mdl_clr, any_oe, halt_oe, halt_val} = '0;
        step(12);
        rst_i = 0;
        chk({tgt_pin_oe_o, tgt_pin_o, pseudo_ground_line_oe_o, busy_o, done_o}, {5'h00, PIN_RST, 3'h0});
        chk(rx_data_o, 32'h0000_0000);
        step(20);
        for (int m = 0; m < 3; m++) run(tpc_mode_t'(m), 1, 0, 0, 7, 32'ha5, 32'h3c, 32'h96);
        run(TPC_JTAG, 1, 1, 3, 31, 32'hc35a_0ff1, 32'h8000_0001, 32'h1e2d_3c4b);
        chk(halt_val, 1'b0);
        run(TPC_JTAG, 1, 0, 1, 0, 32'h0, 32'h1, 32'h1);
        chk(halt_val, 1'b1);
        run(TPC_JTAG, 0, 1, 0, 3, 32'h5, 32'ha, 32'h6);
        vref_low_i = 1;
        step(2);
        run(TPC_SPI, 0, 0, 0, 3, 32'h0, 32'h0, 32'h9);
        chk(any_oe, 1'b0);
        vref_low_i = 0;
        {div_i, len_i} = {4'h3, 5'h1f};
        start_i = 1;
        step(1);
        start_i = 0;
        step(60);
        rst_i = 1;
        #1;
        chk({tgt_pin_oe_o, pseudo_ground_line_oe_o}, 6'h00);
        step(12);
        rst_i = 0;
        step(20);
        run(TPC_SERIAL, 0, 0, 2, 4, 32'h15, 32'h0a, 32'h1b);
        end_of_test;
    end
endmodule
bind tpc_target_port tpc_chk u_chk (.clk_i, .rst_i, .link_clk_i, .mode_i, .halt_en_i, .halt_lpart_i,
    .div_i, .vref_low_i, .tgt_pin_o, .tgt_pin_oe_o, .pseudo_ground_line_o, .pseudo_ground_line_oe_o, .busy_o, .done_o);

// ===== testbench/tpc_chk.sv
// Purpose: port checks for the target pin control block
// Assumes: mode and halt inputs are held steady while busy
// Notes:   pin checks run on the link clock, done on the system clock
`timescale 1ns/1ps
module tpc_chk
    import tpc_pkg::*;
(
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            link_clk_i,
    input  wire tpc_mode_t       mode_i,
    input  wire logic            halt_en_i,
    input  wire logic            halt_lpart_i,
    input  wire logic [3:0]      div_i,
    input  wire logic            vref_low_i,
    input  wire logic [NPIN-1:0] tgt_pin_o,
    input  wire logic [NPIN-1:0] tgt_pin_oe_o,
    input  wire logic            pseudo_ground_line_o,
    input  wire logic            pseudo_ground_line_oe_o,
    input  wire logic            busy_o,
    input  wire logic            done_o
);
    ////////////////////////////////////////////////////////////////////////
    // pin side, sampled on the link clock
    pseudo_ground_line_low_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        pseudo_ground_line_o == 1'b0) else $error("pseudo ground driven high");
    idle_float_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        !busy_o |-> tgt_pin_oe_o == 5'h00 && !pseudo_ground_line_oe_o) else $error("pins driven while idle");
    op_ground_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        tgt_pin_oe_o[PIN_SCLK] |-> pseudo_ground_line_oe_o) else $error("pseudo ground open during shift");
    vref_float_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        vref_low_i [*3] |=> tgt_pin_oe_o == 5'h00) else $error("pins driven with low reference");
    dir_mask_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        tgt_pin_oe_o != 5'h00 |-> tgt_pin_oe_o[3:0] == (mode_i == TPC_JTAG ? DIR_JTAG[3:0] :
        (mode_i == TPC_SPI ? DIR_SPI[3:0] : DIR_SERIAL[3:0]))) else $error("wrong pin directions");
    halt_gate_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        tgt_pin_oe_o[PIN_HALT] |-> halt_en_i && mode_i == TPC_JTAG) else $error("halt driven when off");
    halt_level_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        tgt_pin_oe_o[PIN_HALT] && !tgt_pin_o[PIN_HALT] |-> halt_lpart_i) else $error("halt low wrongly");
    fall_launch_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        tgt_pin_oe_o[PIN_DOUT] && $past(tgt_pin_oe_o[PIN_DOUT]) && ($changed(tgt_pin_o[PIN_DOUT]) ||
        $changed(tgt_pin_o[PIN_MSEL])) |-> $fell(tgt_pin_o[PIN_SCLK])) else $error("launch off fall");
    park_high_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $fell(tgt_pin_oe_o[PIN_DOUT]) |-> $past(tgt_pin_o[PIN_DOUT]) && $past(tgt_pin_o[PIN_MSEL]) &&
        $past(tgt_pin_o[PIN_SCLK]) && ($past(tgt_pin_o[PIN_HALT]) || !$past(tgt_pin_oe_o[PIN_HALT])))
        else $error("pin released from low");
    fast_clock_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $rose(tgt_pin_o[PIN_SCLK]) && div_i == 4'h0 |=> !tgt_pin_o[PIN_SCLK] || !tgt_pin_oe_o[PIN_SCLK])
        else $error("high phase long");
    ////////////////////////////////////////////////////////////////////////
    // host side, system clock
    done_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_o |=> !done_o) else $error("done longer than a cycle");
endmodule

// ===== testbench/tpc_target_model.sv
// Purpose: behavioural target chain on the far side of the pins
// Assumes: clock wire idles high through its pull-up
// Notes:   the parking edge after a frame is ignored past bit 31
`timescale 1ns/1ps
module tpc_target_model
    import tpc_pkg::*;
(
    input  wire logic            clr_i,   // async clear between frames
    input  wire logic            sclk_i,  // shift clock wire level
    input  wire logic            sdi_i,   // data wire from the pod
    input  wire logic            sel_i,   // select wire from the pod
    input  wire logic [WORD-1:0] pat_i,   // bits returned, lsb first
    output logic                 sdo_o,   // data back to the pod
    output logic [WORD-1:0]      cap_d_o, // data bits seen
    output logic [WORD-1:0]      cap_s_o  // select bits seen
);
    logic [5:0] idx;  // bit position, bit 5 marks a full word
    // sample both lines on the rising edge
    always @(posedge sclk_i or posedge clr_i) begin
        if (clr_i) begin
            idx <= 6'h00;
            cap_d_o <= '0;
            cap_s_o <= '0;
        end else if (!idx[5]) begin
            cap_d_o[idx[4:0]] <= sdi_i;
            cap_s_o[idx[4:0]] <= sel_i;
            idx <= idx + 6'h01;
        end
    end
    // present the next return bit on the falling edge
    always @(negedge sclk_i or posedge clr_i) begin
        if (clr_i) sdo_o <= pat_i[0];
        else sdo_o <= pat_i[idx[4:0]];
    end
endmodule
